//--- rtcc_pkg.sv
// Purpose: Shared constants for the calendar counters and event registers.
// Assumes: 32-bit classic Wishbone register bus, word aligned.
// Notes: Counter fields are BCD digits; reserved bits read as zero.
package rtcc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] OFS_MONTH_DAY = 8'h00;
   localparam logic [7:0] OFS_YEAR_WEEKDAY = 8'h04;
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h08;
   localparam logic [7:0] OFS_EVENT_ENABLES = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Month/day register layout.
   localparam int MON_TENS_BIT = 12;
   localparam int MON_UNITS_LSB = 8;
   localparam int DAY_TENS_LSB = 4;
   localparam int DAY_UNITS_LSB = 0;

   // Year/weekday register layout.
   localparam int WEEKDAY_LSB = 8;
   localparam int YEAR_TENS_LSB = 4;
   localparam int YEAR_UNITS_LSB = 0;

   // Status register layout.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_IRQ_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Event bit positions, shared by the flag and enable registers.
   localparam int EVT_TRIM_DONE = 15;
   localparam int EVT_SW_ONE_HZ = 14;
   localparam int EVT_SW_TEN_HZ = 13;
   localparam int EVT_SW_HUNDRED_HZ = 12;
   localparam int EVT_ALARM = 8;
   localparam int EVT_DAY_TICK = 7;
   localparam int EVT_HOUR_TICK = 6;
   localparam int EVT_MINUTE_TICK = 5;
   localparam int EVT_SECOND_TICK = 4;
   localparam int EVT_HALF_SECOND = 3;
   localparam int EVT_QUARTER_SECOND = 2;
   localparam int EVT_EIGHTH_SECOND = 1;
   localparam int EVT_THIRTYSECOND = 0;

   // Implemented event bits; bits 11 to 9 are reserved.
   localparam logic [15:0] EVT_IMPL_MASK = 16'hF1FF;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and BCD limits.
   localparam logic RST_MON_TENS = 1'h0;
   localparam logic [3:0] RST_MON_UNITS = 4'h1;
   localparam logic [1:0] RST_DAY_TENS = 2'h0;
   localparam logic [3:0] RST_DAY_UNITS = 4'h1;
   localparam logic [2:0] RST_WEEKDAY = 3'h0;
   localparam logic [3:0] RST_YEAR_DIGIT = 4'h0;
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [3:0] BCD_ZERO = 4'h0;
   localparam logic [3:0] BCD_ONE = 4'h1;
   localparam logic [3:0] BCD_TWO = 4'h2;
   localparam logic [2:0] WEEKDAY_LAST = 3'h6;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] MONTH_APR = 8'h04;
   localparam logic [7:0] MONTH_JUN = 8'h06;
   localparam logic [7:0] MONTH_SEP = 8'h09;
   localparam logic [7:0] MONTH_NOV = 8'h11;
   localparam logic [5:0] DAYS_31 = 6'h31;
   localparam logic [5:0] DAYS_30 = 6'h30;
   localparam logic [5:0] DAYS_29 = 6'h29;
   localparam logic [5:0] DAYS_28 = 6'h28;

endpackage : rtcc_pkg

//--- rtcc_day_limit.sv
// Purpose: Last day of the current month as a BCD value.
// Assumes: Month and year digits hold legal BCD values.
// Notes: Purely combinational; a year divisible by four is a leap year.
`timescale 1ns/1ps
module rtcc_day_limit (
   input wire logic month_tens,
   input wire logic [3:0] month_units,
   input wire logic [3:0] year_tens,
   input wire logic [3:0] year_units,
   output logic [5:0] last_day
);

   logic [7:0] month_bcd;
   logic leap;

   // Divisible by four: even tens with units 0/4/8, odd tens with units 2/6.
   assign month_bcd = {3'h0, month_tens, month_units};
   assign leap = year_tens[0] ? (year_units == 4'h2 || year_units == 4'h6)
                              : (year_units[1:0] == 2'h0);

   // Month length selection.
   always_comb begin
      if (month_bcd == rtcc_pkg::MONTH_FEB) begin
         last_day = leap ? rtcc_pkg::DAYS_29 : rtcc_pkg::DAYS_28;
      end else if (month_bcd == rtcc_pkg::MONTH_APR || month_bcd == rtcc_pkg::MONTH_JUN ||
                   month_bcd == rtcc_pkg::MONTH_SEP || month_bcd == rtcc_pkg::MONTH_NOV) begin
         last_day = rtcc_pkg::DAYS_30;
      end else begin
         last_day = rtcc_pkg::DAYS_31;
      end
   end

endmodule : rtcc_day_limit

//--- rtcc_event_bank.sv
// Purpose: Sticky event flags, enable bits and the combined interrupt.
// Assumes: Event pulses come from logic on the same clock.
// Notes: A set in the same cycle as a clear keeps the flag set.
`timescale 1ns/1ps
module rtcc_event_bank #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] IMPL_MASK = rtcc_pkg::EVT_IMPL_MASK
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] event_set,
   input wire logic [WIDTH-1:0] flag_clear,
   input wire logic enable_we,
   input wire logic [WIDTH-1:0] enable_wdata,
   output logic [WIDTH-1:0] flags_q,
   output logic [WIDTH-1:0] enables_q,
   output logic irq
);

   // One flag and one enable per event bit; reserved bits stay zero.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               flags_q[i] <= 1'b0;
            end else begin
               flags_q[i] <= event_set[i] | (flags_q[i] & ~flag_clear[i]);
            end
         end
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               enables_q[i] <= 1'b0;
            end else if (enable_we) begin
               enables_q[i] <= enable_wdata[i];
            end
         end
      end else begin : g_rsvd
         assign flags_q[i] = 1'b0;
         assign enables_q[i] = 1'b0;
      end
   end

   assign irq = |(flags_q & enables_q);

endmodule : rtcc_event_bank

//--- rtcc_calendar.sv
// Purpose: Calendar counters and event registers of the real-time clock.
// Assumes: Classic Wishbone slave, 32-bit data; hour carry and events on mclk.
// Notes: Counters advance on each hour counter carry out of the last hour.
//
// Functional notes
// - The month is a one-bit tens and four-bit units BCD count from 1 to 12, read and written by software.
// - The day is a two-bit tens and four-bit units BCD count from 1 to 31, 30, 29 or 28 by month and year.
// - The weekday counts modulo seven from 0 for Sunday to 6 for Saturday.
// - The year is two four-bit BCD digits from 0 to 99, read and written by software.
// - A flag reads one after its event, is cleared by writing one and kept by writing zero.
// - Bit 15 is trim done, bits 14 to 12 the stopwatch 1, 10 and 100 Hz events, bits 11 to 9 reserved as zero.
// - Bits 8 to 0 are alarm, day, hour, minute, second, half, quarter, eighth and 1/32 second events.
// - Enable bits are read and written, one enables, and all flags and enables reset to zero.
// - The hour counter, outside this block, carries into the day counter.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module rtcc_calendar #(
   parameter int EVT_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic hour_carry,
   input wire logic counter_busy_flag,
   input wire logic [EVT_WIDTH-1:0] event_pulse,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic ack_q;
   logic [31:0] rdata_q;
   logic req;
   logic wr_cycle;
   logic wr_month_day;
   logic wr_year_weekday;
   logic wr_flags;
   logic wr_enables;

   logic month_tens_digit_q;
   logic [3:0] month_units_digit_q;
   logic [1:0] day_tens_digit_q;
   logic [3:0] day_units_digit_q;
   logic [2:0] weekday_count_q;
   logic [3:0] year_tens_digit_q;
   logic [3:0] year_units_digit_q;

   logic [5:0] last_day;
   logic day_at_end;
   logic month_at_end;
   logic year_at_end;

   logic [EVT_WIDTH-1:0] event_set;
   logic [EVT_WIDTH-1:0] flag_clear;
   logic [EVT_WIDTH-1:0] flags_q;
   logic [EVT_WIDTH-1:0] enables_q;

   logic [15:0] month_day_view;
   logic [15:0] year_weekday_view;
   logic [31:0] rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave.

   // A request is live while cycle and strobe are both high.
   assign req = wb_cyc_i & wb_stb_i;

   // Acknowledge one cycle after the request, then drop for one cycle.
   // The registered acknowledge gives every register one fixed wait state.
   // The read mux therefore has a whole cycle to settle before data is caught.
   // A write lands only if the master holds its request through that edge.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // The acknowledge leaves straight from its flip-flop.
   assign wb_ack_o = ack_q;

   // Nothing here blocks a counter write while the busy input is high.
   // Such a write wins over a carry in the same edge, and that carry is lost.
   // Writes land on the edge at which the master samples the acknowledge.
   assign wr_cycle = req & wb_we_i & ack_q;
   assign wr_month_day = wr_cycle && (wb_adr_i == rtcc_pkg::OFS_MONTH_DAY);
   assign wr_year_weekday = wr_cycle && (wb_adr_i == rtcc_pkg::OFS_YEAR_WEEKDAY);
   assign wr_flags = wr_cycle && (wb_adr_i == rtcc_pkg::OFS_EVENT_FLAGS);
   assign wr_enables = wr_cycle && (wb_adr_i == rtcc_pkg::OFS_EVENT_ENABLES);

   ////////////////////////////////////////////////////////////////////////////
   // Calendar carry chain.

   // It is purely combinational, so a date write is seen by the next carry.
   // Month length for the current month and year.
   rtcc_day_limit u_day_limit (
      .month_tens(month_tens_digit_q),
      .month_units(month_units_digit_q),
      .year_tens(year_tens_digit_q),
      .year_units(year_units_digit_q),
      .last_day(last_day)
   );

   // The month moves only when the day wraps.
   // The year moves only when both the day and the month wrap.
   // overflow carry chain.
   assign day_at_end = ({day_tens_digit_q, day_units_digit_q} == last_day);
   assign month_at_end = month_tens_digit_q && (month_units_digit_q == rtcc_pkg::BCD_TWO);
   assign year_at_end = (year_tens_digit_q == rtcc_pkg::BCD_NINE) &&
                        (year_units_digit_q == rtcc_pkg::BCD_NINE);

   ////////////////////////////////////////////////////////////////////////////
   // Day counter; software writes of byte lane 0 take priority over a carry.

   // A day loaded above the month's last day is not repaired here.
   // It runs on until its digits wrap, so software must load legal dates.
   // day BCD count.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         day_tens_digit_q <= rtcc_pkg::RST_DAY_TENS;
         day_units_digit_q <= rtcc_pkg::RST_DAY_UNITS;
      end else if (wr_month_day && wb_sel_i[0]) begin
         day_tens_digit_q <= wb_dat_i[rtcc_pkg::DAY_TENS_LSB +: 2];
         day_units_digit_q <= wb_dat_i[rtcc_pkg::DAY_UNITS_LSB +: 4];
      end else if (hour_carry) begin
         if (day_at_end) begin
            day_tens_digit_q <= rtcc_pkg::RST_DAY_TENS;
            day_units_digit_q <= rtcc_pkg::BCD_ONE;
         end else if (day_units_digit_q == rtcc_pkg::BCD_NINE) begin
            day_tens_digit_q <= day_tens_digit_q + 2'h1;
            day_units_digit_q <= rtcc_pkg::BCD_ZERO;
         end else begin
            day_units_digit_q <= day_units_digit_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Month counter; software writes of byte lane 1.

   // An illegal month loaded by software is not repaired here.
   // It only returns to a legal count through the normal increments.
   // month BCD count.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         month_tens_digit_q <= rtcc_pkg::RST_MON_TENS;
         month_units_digit_q <= rtcc_pkg::RST_MON_UNITS;
      end else if (wr_month_day && wb_sel_i[1]) begin
         month_tens_digit_q <= wb_dat_i[rtcc_pkg::MON_TENS_BIT];
         month_units_digit_q <= wb_dat_i[rtcc_pkg::MON_UNITS_LSB +: 4];
      end else if (hour_carry && day_at_end) begin
         if (month_at_end) begin
            month_tens_digit_q <= 1'b0;
            month_units_digit_q <= rtcc_pkg::BCD_ONE;
         end else if (month_units_digit_q == rtcc_pkg::BCD_NINE) begin
            month_tens_digit_q <= 1'b1;
            month_units_digit_q <= rtcc_pkg::BCD_ZERO;
         end else begin
            month_units_digit_q <= month_units_digit_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Year counter; software writes of byte lane 0.

   // Year 00 counts as a leap year in the day limit logic.
   // year BCD count.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         year_tens_digit_q <= rtcc_pkg::RST_YEAR_DIGIT;
         year_units_digit_q <= rtcc_pkg::RST_YEAR_DIGIT;
      end else if (wr_year_weekday && wb_sel_i[0]) begin
         year_tens_digit_q <= wb_dat_i[rtcc_pkg::YEAR_TENS_LSB +: 4];
         year_units_digit_q <= wb_dat_i[rtcc_pkg::YEAR_UNITS_LSB +: 4];
      end else if (hour_carry && day_at_end && month_at_end) begin
         if (year_at_end) begin
            year_tens_digit_q <= rtcc_pkg::BCD_ZERO;
            year_units_digit_q <= rtcc_pkg::BCD_ZERO;
         end else if (year_units_digit_q == rtcc_pkg::BCD_NINE) begin
            year_tens_digit_q <= year_tens_digit_q + 4'h1;
            year_units_digit_q <= rtcc_pkg::BCD_ZERO;
         end else begin
            year_units_digit_q <= year_units_digit_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Weekday counter; software writes of byte lane 1.

   // The weekday runs free of the date, so software sets it to match.
   // A loaded seven wraps to Sunday on the next carry.
   // weekday modulo seven.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         weekday_count_q <= rtcc_pkg::RST_WEEKDAY;
      end else if (wr_year_weekday && wb_sel_i[1]) begin
         weekday_count_q <= wb_dat_i[rtcc_pkg::WEEKDAY_LSB +: 3];
      end else if (hour_carry) begin
         if (weekday_count_q >= rtcc_pkg::WEEKDAY_LAST) begin
            weekday_count_q <= rtcc_pkg::RST_WEEKDAY;
         end else begin
            weekday_count_q <= weekday_count_q + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flags and enables.

   // The hour carry that rolls the date also marks the day event.
   // Software thus sees the day event without a separate day pulse.
   // day carry feeds day event.
   always_comb begin
      event_set = event_pulse;
      event_set[rtcc_pkg::EVT_DAY_TICK] = event_pulse[rtcc_pkg::EVT_DAY_TICK] | hour_carry;
   end

   // Flag and enable writes use the whole word and ignore the byte selects.
   // write one clears.
   assign flag_clear = wr_flags ? wb_dat_i[EVT_WIDTH-1:0] : '0;

   // Sticky flags, enables and the masked interrupt.
   rtcc_event_bank #(
      .WIDTH(EVT_WIDTH),
      .IMPL_MASK(rtcc_pkg::EVT_IMPL_MASK)
   ) u_event_bank (
      .mclk(mclk),
      .reset_n(reset_n),
      .event_set(event_set),
      .flag_clear(flag_clear),
      .enable_we(wr_enables),
      .enable_wdata(wb_dat_i[EVT_WIDTH-1:0]),
      .flags_q(flags_q),
      .enables_q(enables_q),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   // Register views with reserved bits at zero.
   always_comb begin
      month_day_view = 16'h0000;
      month_day_view[rtcc_pkg::MON_TENS_BIT] = month_tens_digit_q;
      month_day_view[rtcc_pkg::MON_UNITS_LSB +: 4] = month_units_digit_q;
      month_day_view[rtcc_pkg::DAY_TENS_LSB +: 2] = day_tens_digit_q;
      month_day_view[rtcc_pkg::DAY_UNITS_LSB +: 4] = day_units_digit_q;
      year_weekday_view = 16'h0000;
      year_weekday_view[rtcc_pkg::WEEKDAY_LSB +: 3] = weekday_count_q;
      year_weekday_view[rtcc_pkg::YEAR_TENS_LSB +: 4] = year_tens_digit_q;
      year_weekday_view[rtcc_pkg::YEAR_UNITS_LSB +: 4] = year_units_digit_q;
   end

   // The status word gives the busy level and the combined interrupt.
   // A poll loop then need not read the flag and enable words.
   // Address decode; an unmapped address reads zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
         rtcc_pkg::OFS_MONTH_DAY: rdata_d[15:0] = month_day_view;
         rtcc_pkg::OFS_YEAR_WEEKDAY: rdata_d[15:0] = year_weekday_view;
         rtcc_pkg::OFS_EVENT_FLAGS: rdata_d[EVT_WIDTH-1:0] = flags_q;
         rtcc_pkg::OFS_EVENT_ENABLES: rdata_d[EVT_WIDTH-1:0] = enables_q;
         rtcc_pkg::OFS_STATUS: begin
            rdata_d[rtcc_pkg::STAT_BUSY_BIT] = counter_busy_flag;
            rdata_d[rtcc_pkg::STAT_IRQ_BIT] = irq;
         end
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // The word is caught on the taking edge and stands while ack is high.
   // It then holds until the next request is taken.
   // Read data is captured together with the acknowledge.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (req & ~ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   // Read data always comes straight from the capture register.
   assign wb_dat_o = rdata_q;

endmodule : rtcc_calendar

//--- rtcc_calendar_checker.sv
// Purpose: Concurrent checks on the ports of the calendar block.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Bound to rtcc_calendar from the testbench top file.
`timescale 1ns/1ps
module rtcc_calendar_checker #(
   parameter int EVT_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic hour_carry,
   input wire logic counter_busy_flag,
   input wire logic [EVT_WIDTH-1:0] event_pulse,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////////
   logic req;
   logic rd_ack;
   logic wr_ack;
   logic evt_any;
   // Helper terms, so that the sampled-value functions see plain signals.
   assign req = wb_cyc_i && wb_stb_i;
   assign rd_ack = wb_ack_o && !wb_we_i;
   assign wr_ack = wb_ack_o && wb_we_i;
   assign evt_any = (|(event_pulse & EVT_WIDTH'(rtcc_pkg::EVT_IMPL_MASK))) || hour_carry;

   ////////////////////////////////////////////////////////////////////////////
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge stayed high");
   ack_latency_a: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("acknowledge missing one cycle after request");
   ack_cause_a: assert property (wb_ack_o |-> $past(req))
      else $error("acknowledge without request");
   upper_zero_a: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   unmapped_zero_a: assert property (rd_ack && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   reserved_events_a: assert property (rd_ack && (wb_adr_i == 8'h08 || wb_adr_i == 8'h0C)
      |-> wb_dat_o[11:9] == 3'h0)
      else $error("reserved event bits not zero");
   month_range_a: assert property (rd_ack && wb_adr_i == 8'h00 |->
      wb_dat_o[12:8] inside {[5'h01:5'h09], [5'h10:5'h12]} && wb_dat_o[15:13] == 3'h0)
      else $error("month out of range");
   day_range_a: assert property (rd_ack && wb_adr_i == 8'h00 |-> wb_dat_o[7:6] == 2'h0 &&
      wb_dat_o[5:0] inside {[6'h01:6'h09], [6'h10:6'h19], [6'h20:6'h29], [6'h30:6'h31]})
      else $error("day out of range");
   weekday_range_a: assert property (rd_ack && wb_adr_i == 8'h04 |->
      wb_dat_o[10:8] <= 3'h6 && wb_dat_o[15:11] == 5'h00)
      else $error("weekday out of range");
   busy_status_a: assert property (rd_ack && wb_adr_i == 8'h10 |->
      wb_dat_o[0] == $past(counter_busy_flag))
      else $error("busy status mismatch");
   irq_rise_a: assert property ($rose(irq) |-> $past(evt_any) || $past(wr_ack))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_ack))
      else $error("interrupt fell without write");

   ////////////////////////////////////////////////////////////////////////////
   cover property (wr_ack);
   cover property (rd_ack);
   cover property ($rose(irq));
   cover property (hour_carry);
endmodule : rtcc_calendar_checker

//--- rtcc_calendar_test.sv
// Purpose: Self-checking bench for the calendar counters and event registers.
// Assumes: The Wishbone slave answers in its own time; every wait is bounded.
// Notes: An integer model predicts every value read back.
`timescale 1ns/1ps
module rtcc_calendar_test;
   logic mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hour_carry, irq;
   logic counter_busy_flag;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [15:0] event_pulse;
   int mismatches, checks, seed, mo, dy, wk, yr, fl, en, ev, bsy;
   int tm[10] = '{2, 2, 2, 4, 1, 12, 6, 9, 11, 3};
   int td[10] = '{28, 28, 29, 30, 31, 31, 30, 30, 30, 19};
   int ty[10] = '{23, 24, 24, 5, 7, 99, 10, 11, 12, 40};

   rtcc_calendar #(.EVT_WIDTH(16)) DUT (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hour_carry(hour_carry),
      .counter_busy_flag(counter_busy_flag), .event_pulse(event_pulse), .irq(irq));

   // Free-running 40 ns clock.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One classic Wishbone cycle; held until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   // Reads one register and compares it with the model.
   task automatic rdc(input logic [7:0] adr, input int exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, 32'(exp));
   endtask : rdc

   ////////////////////////////////////////////////////////////////////////////
   // Model helpers: BCD packing of the two counter words.
   function automatic int bcd(input int v);
      return (v / 10) * 16 + v % 10;
   endfunction : bcd
   function automatic int md();
      return bcd(mo) * 256 + bcd(dy);
   endfunction : md
   function automatic int yw();
      return wk * 256 + bcd(yr);
   endfunction : yw

   // Loads a date into the model and the design.
   task automatic setd(input int m, input int d, input int y, input int w);
      mo = m;
      dy = d;
      yr = y;
      wk = w;
      wb(1'b1, rtcc_pkg::OFS_MONTH_DAY, 32'(md()));
      wb(1'b1, rtcc_pkg::OFS_YEAR_WEEKDAY, 32'(yw()));
   endtask : setd

   // Pulses the hour carry and advances the model by one day.
   task automatic step;
      int last;
      last = (mo == 2) ? ((yr % 4 == 0) ? 29 : 28) :
         (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
      @(posedge mclk);
      hour_carry <= 1'b1;
      @(posedge mclk);
      hour_carry <= 1'b0;
      dy = (dy == last) ? 1 : dy + 1;
      mo = (dy == 1) ? ((mo == 12) ? 1 : mo + 1) : mo;
      yr = (dy == 1 && mo == 1) ? (yr + 1) % 100 : yr;
      wk = (wk + 1) % 7;
      fl = fl | 32'h80;
   endtask : step

   // Pulses a set of event lines for one cycle.
   task automatic pulse(input int e);
      @(posedge mclk);
      event_pulse <= 16'(e);
      @(posedge mclk);
      event_pulse <= 16'h0000;
      fl = fl | (e & 32'hF1FF);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      seed = 32'hc48528e7;
      {mismatches, checks, fl, en, wk, yr} = '0;
      mo = 1;
      dy = 1;
      reset_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, hour_carry, counter_busy_flag} = '0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      event_pulse = 16'h0000;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rdc(rtcc_pkg::OFS_MONTH_DAY, md());
      rdc(rtcc_pkg::OFS_YEAR_WEEKDAY, yw());
      rdc(rtcc_pkg::OFS_EVENT_FLAGS, 0);
      rdc(rtcc_pkg::OFS_EVENT_ENABLES, 0);
      wb(1'b1, 8'h14, 32'hFFFFFFFF);
      rdc(8'h14, 0);
      // Date rollovers from a table, including month and year wrap.
      for (int i = 0; i < 10; i++) begin
         setd(tm[i], td[i], ty[i], ($random(seed) & 32'h7FFF) % 7);
         rdc(rtcc_pkg::OFS_MONTH_DAY, md());
         step();
         rdc(rtcc_pkg::OFS_MONTH_DAY, md());
         rdc(rtcc_pkg::OFS_YEAR_WEEKDAY, yw());
      end
      rdc(rtcc_pkg::OFS_EVENT_FLAGS, fl);
      wb(1'b1, rtcc_pkg::OFS_EVENT_FLAGS, 32'hFFFF);
      fl = 0;
      // Each event bit alone: enable, set, keep on zero, clear on one.
      for (int b = 0; b < 16; b++) begin
         en = (1 << b) & 32'hF1FF;
         wb(1'b1, rtcc_pkg::OFS_EVENT_ENABLES, 32'(1 << b));
         rdc(rtcc_pkg::OFS_EVENT_ENABLES, en);
         pulse(1 << b);
         rdc(rtcc_pkg::OFS_EVENT_FLAGS, fl);
         chk({31'h0, irq}, 32'((fl & en) != 0));
         wb(1'b1, rtcc_pkg::OFS_EVENT_FLAGS, 32'h0);
         rdc(rtcc_pkg::OFS_EVENT_FLAGS, fl);
         wb(1'b1, rtcc_pkg::OFS_EVENT_FLAGS, 32'(1 << b));
         fl = 0;
         rdc(rtcc_pkg::OFS_EVENT_FLAGS, 0);
         chk({31'h0, irq}, 32'h0);
      end
      // Random events and masks, with the busy level seen in status.
      for (int i = 0; i < 6; i++) begin
         en = $random(seed) & 32'hFFFF;
         ev = $random(seed) & 32'hFFFF;
         bsy = $random(seed) & 1;
         counter_busy_flag <= 1'(bsy);
         wb(1'b1, rtcc_pkg::OFS_EVENT_ENABLES, 32'(en));
         en = en & 32'hF1FF;
         pulse(ev);
         rdc(rtcc_pkg::OFS_EVENT_FLAGS, fl);
         chk({31'h0, irq}, 32'((fl & en) != 0));
         rdc(rtcc_pkg::OFS_STATUS, (((fl & en) != 0) ? 2 : 0) + bsy);
      end
      end_sim();
   end

   // Stops a run that hangs outside the bus waits.
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      end_sim();
   end
endmodule : rtcc_calendar_test

bind rtcc_calendar rtcc_calendar_checker #(.EVT_WIDTH(EVT_WIDTH)) u_chk (.mclk(mclk),
   .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .hour_carry(hour_carry), .counter_busy_flag(counter_busy_flag),
   .event_pulse(event_pulse), .irq(irq));
